// ==== rocof_prot.sv ====
/*
 Rate-of-change-of-frequency protection element with register port,
 start/trip outputs, change events and a level interrupt.
 Assumes synchronous inputs, a frequency measurement strobe per period
 and a voltage magnitude in the same unit as the rated-voltage register.
*/
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
module rocof_prot import rocof_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int FREQ_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic meas_strobe,
	input wire logic meas_valid,
	input wire logic [FREQ_W-1:0] meas_freq,
	input wire logic [15:0] volt_mag,
	input wire logic rocof_block_in,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic rocof_general_start_out,
	output logic rocof_general_trip_out,
	output logic start_event,
	output logic trip_event
);
	localparam int PRW = $clog2(TICK_CYCLES);
	localparam int PW = 2 * FREQ_W + 2;
	localparam logic [PRW-1:0] PRE_LAST = PRW'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("rocof_prot: TICK_CYCLES must be at least 2");
	end
	if (FREQ_W < 8 || FREQ_W > 20) begin : g_bad_w
		$error("rocof_prot: FREQ_W out of range");
	end

	typedef struct packed {
		logic en;
		logic sonly;
		logic [9:0] thr;
		logic [13:0] dly;
		logic [15:0] rated;
		logic [3:0] stat;
		logic [3:0] mask;
		logic [PRW-1:0] pre;
		logic tick;
		logic fault;
		logic [13:0] ms;
		logic start;
		logic trip;
		logic ev_st;
		logic ev_tr;
		logic irq;
		logic [31:0] rdata;
	} prot_s;

	prot_s s_q;
	prot_s s_d;

	logic [FREQ_W-1:0] freq;
	logic freq_ok;
	logic freq_upd;
	logic signed [PW-1:0] slope_prod;
	logic slope_valid;

	freq_qualify #(.FREQ_W(FREQ_W)) u_qual (
		.clock(clock),
		.rst(rst),
		.meas_strobe(meas_strobe),
		.meas_valid(meas_valid),
		.meas_freq(meas_freq),
		.freq_q(freq),
		.freq_ok(freq_ok),
		.freq_upd(freq_upd)
	);

	slope_calc #(.FREQ_W(FREQ_W), .DEPTH(HIST_DEPTH)) u_slope (
		.clock(clock),
		.rst(rst),
		.clear(!freq_ok),
		.freq_upd(freq_upd),
		.freq(freq),
		.prod_q(slope_prod),
		.prod_valid(slope_valid)
	);

	// Slope comparison, all in scaled integers
	logic thr_neg;
	logic [9:0] thr_abs;
	logic [9:0] ratio;
	logic signed [47:0] pick_s;
	logic signed [47:0] pd_s;
	logic volt_ok;
	logic evaluate;
	logic pickup;
	logic drop;

	always_comb begin
		thr_neg = s_q.thr[9];
		thr_abs = thr_neg ? 10'(-s_q.thr) : s_q.thr;
		// Exactly 0.50 Hz/s takes the finer ratio
		ratio = (thr_abs > THR_KNEE) ? RATIO_HI : RATIO_LO;
		pick_s = $signed(48'(thr_abs) * 48'(SLOPE_SCALE));
		pd_s = 48'(slope_prod);
		// Negative threshold watches falling frequency
		if (thr_neg) begin
			pd_s = -pd_s;
		end
		volt_ok = (20'(volt_mag) * 20'(VOLT_DIV)) > 20'(s_q.rated);
		evaluate = s_q.en && freq_ok && slope_valid && volt_ok;
		pickup = pd_s > pick_s;
		drop = (pd_s * $signed(48'(RATIO_DEN))) <
			(pick_s * $signed(48'(ratio)));
	end

	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic thr_in_range;
	logic dly_in_range;

	always_comb begin
		s_d = s_q;
		ev_set = 4'h0;
		ev_clr = 4'h0;
		thr_in_range = $signed(reg_wdata[9:0]) >= $signed(THR_MIN) &&
			$signed(reg_wdata[9:0]) <= $signed(THR_MAX) &&
			reg_wdata[31:10] == {22{reg_wdata[9]}};
		dly_in_range = reg_wdata[13:0] >= DLY_MIN_MS &&
			reg_wdata[13:0] <= DLY_MAX_MS && reg_wdata[31:14] == 18'h0;

		// Millisecond prescaler
		s_d.tick = 1'b0;
		if (s_q.pre == PRE_LAST) begin
			s_d.pre = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.pre = s_q.pre + PRW'(1);
		end

		// Fault latch with hysteresis
		if (!evaluate) begin
			s_d.fault = 1'b0;
		end else if (s_q.fault) begin
			s_d.fault = !drop;
		end else begin
			s_d.fault = pickup;
		end

		// Timer runs from onset, cleared when fault goes
		if (!s_d.fault) begin
			s_d.ms = 14'h0;
		end else if (s_q.fault && s_q.tick && s_q.ms != MS_SAT) begin
			s_d.ms = s_q.ms + 14'h1;
		end

		s_d.start = s_q.en && !rocof_block_in && s_q.fault &&
			s_q.ms >= COMP_DELAY_MS;
		s_d.trip = s_q.en && !rocof_block_in && !s_q.sonly &&
			s_q.fault && s_q.ms >= s_q.dly;

		// No events while disabled, so switching off stays silent
		s_d.ev_st = s_q.en && (s_d.start != s_q.start);
		s_d.ev_tr = s_q.en && (s_d.trip != s_q.trip);
		ev_set[EV_START_ON] = s_d.ev_st && s_d.start;
		ev_set[EV_START_OFF] = s_d.ev_st && !s_d.start;
		ev_set[EV_TRIP_ON] = s_d.ev_tr && s_d.trip;
		ev_set[EV_TRIP_OFF] = s_d.ev_tr && !s_d.trip;

		// Register writes; out-of-range settings are ignored
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					s_d.en = reg_wdata[CTRL_EN_BIT];
					s_d.sonly = reg_wdata[CTRL_SONLY_BIT];
				end
				OFS_THR: begin
					if (thr_in_range) begin
						s_d.thr = reg_wdata[9:0];
					end
				end
				OFS_DLY: begin
					if (dly_in_range) begin
						s_d.dly = reg_wdata[13:0];
					end
				end
				OFS_RATED: s_d.rated = reg_wdata[15:0];
				OFS_ISTAT: ev_clr = reg_wdata[3:0];
				OFS_IMASK: s_d.mask = reg_wdata[3:0];
				default: ;
			endcase
		end
		// A new event beats a same-cycle clear
		s_d.stat = (s_q.stat & ~ev_clr) | ev_set;
		s_d.irq = |(s_d.stat & s_d.mask);

		s_d.rdata = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: begin
					s_d.rdata[CTRL_EN_BIT] = s_q.en;
					s_d.rdata[CTRL_SONLY_BIT] = s_q.sonly;
				end
				OFS_THR: s_d.rdata = {{22{s_q.thr[9]}}, s_q.thr};
				OFS_DLY: s_d.rdata = {18'h0, s_q.dly};
				OFS_RATED: s_d.rdata = {16'h0, s_q.rated};
				OFS_STATUS: begin
					s_d.rdata[STS_START_BIT] = s_q.start;
					s_d.rdata[STS_TRIP_BIT] = s_q.trip;
					s_d.rdata[STS_FOK_BIT] = freq_ok;
				end
				OFS_ISTAT: s_d.rdata = {28'h0, s_q.stat};
				OFS_IMASK: s_d.rdata = {28'h0, s_q.mask};
				OFS_FREQ: s_d.rdata = 32'(freq);
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '{thr: THR_RST, dly: DLY_RST, rated: RATED_RST,
				default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign irq = s_q.irq;
	assign rocof_general_start_out = s_q.start;
	assign rocof_general_trip_out = s_q.trip;
	assign start_event = s_q.ev_st;
	assign trip_event = s_q.ev_tr;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_start_only;
		s_q.sonly |=> !s_q.trip;
	endproperty
	a_start_only: assert property (p_start_only)
		else $error("trip raised under start-only option");

	property p_thr_range;
		$signed(s_q.thr) >= $signed(THR_MIN) &&
			$signed(s_q.thr) <= $signed(THR_MAX);
	endproperty
	a_thr_range: assert property (p_thr_range)
		else $error("threshold setting out of range");

	property p_dly_range;
		s_q.dly >= DLY_MIN_MS && s_q.dly <= DLY_MAX_MS;
	endproperty
	a_dly_range: assert property (p_dly_range)
		else $error("delay setting out of range");

	property p_block;
		rocof_block_in |=> !s_q.start && !s_q.trip;
	endproperty
	a_block: assert property (p_block)
		else $error("output active while blocked");

	property p_start_cause;
		$rose(s_q.start) |-> $past(s_q.fault) &&
			$past(s_q.ms) >= COMP_DELAY_MS;
	endproperty
	a_start_cause: assert property (p_start_cause)
		else $error("start without 100 ms of fault");

	property p_trip_time;
		$rose(s_q.trip) |-> $past(s_q.ms) >= $past(s_q.dly);
	endproperty
	a_trip_time: assert property (p_trip_time)
		else $error("trip before the set delay");

	property p_trip_due;
		s_q.en && s_q.fault && s_q.ms >= s_q.dly && !s_q.sonly &&
			!rocof_block_in |=> s_q.trip;
	endproperty
	a_trip_due: assert property (p_trip_due)
		else $error("trip missing after delay");

	property p_event;
		$changed(s_q.start) && $past(s_q.en) |-> s_q.ev_st;
	endproperty
	a_event: assert property (p_event)
		else $error("start change without event");

	property p_onset;
		$rose(s_q.fault) |-> s_q.ms == 14'h0 ##1 s_q.ms <= 14'h1;
	endproperty
	a_onset: assert property (p_onset)
		else $error("timer not started from zero at onset");

	property p_release;
		s_q.fault && evaluate && drop |=> !s_q.fault;
	endproperty
	a_release: assert property (p_release)
		else $error("fault held below reset level");

	property p_pickup;
		!s_q.fault && evaluate && pickup |=> s_q.fault;
	endproperty
	a_pickup: assert property (p_pickup)
		else $error("fault not picked up above threshold");

	property p_volt;
		!volt_ok |=> !s_q.fault;
	endproperty
	a_volt: assert property (p_volt)
		else $error("evaluated with low voltage");

	property p_disabled;
		!s_q.en |=> !s_q.start && !s_q.trip && !s_q.ev_st && !s_q.ev_tr;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("activity while disabled");

	property p_timer_clear;
		!s_q.fault |-> s_q.ms == 14'h0;
	endproperty
	a_timer_clear: assert property (p_timer_clear)
		else $error("timer kept without fault");

	c_trip: cover property ($rose(s_q.trip));
	c_start_drop: cover property ($fell(s_q.start) && s_q.en);
	c_blocked: cover property (s_q.fault && rocof_block_in);
	c_sonly: cover property (s_q.start && s_q.sonly);
endmodule

// ==== rocof_pkg.sv ====
/*
 Shared constants of the rate-of-change-of-frequency protection element:
 clock rate, timing, setting ranges, register offsets and field positions.
 Assumes a single 20 MHz clock and byte addresses on the register port.
*/
package rocof_pkg;
	localparam int CLK_FREQ_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / MS_PER_S;
	localparam logic [13:0] COMP_DELAY_MS = 14'h0064;
	localparam logic [13:0] DLY_MIN_MS = 14'h00c8;
	localparam logic [13:0] DLY_MAX_MS = 14'h2710;
	localparam logic [13:0] DLY_RST = 14'h00c8;
	localparam logic [13:0] MS_SAT = 14'h3fff;
	// Threshold in 0.01 Hz/s, two's complement
	localparam logic [9:0] THR_MIN = 10'h20c;
	localparam logic [9:0] THR_MAX = 10'h1f4;
	localparam logic [9:0] THR_RST = 10'h032;
	localparam logic [9:0] THR_KNEE = 10'h032;
	// Freq in mHz over 5 periods: 0.01 Hz/s = df*f / 50000
	localparam logic [15:0] SLOPE_SCALE = 16'hc350;
	localparam logic [9:0] RATIO_HI = 10'h398;
	localparam logic [9:0] RATIO_LO = 10'h3e7;
	localparam logic [9:0] RATIO_DEN = 10'h3e8;
	localparam logic [3:0] VOLT_DIV = 4'ha;
	localparam logic [15:0] RATED_RST = 16'h03e8;
	localparam logic [2:0] QUAL_CNT = 3'h4;
	localparam int HIST_DEPTH = 5;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_THR = 8'h04;
	localparam logic [7:0] OFS_DLY = 8'h08;
	localparam logic [7:0] OFS_RATED = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ISTAT = 8'h14;
	localparam logic [7:0] OFS_IMASK = 8'h18;
	localparam logic [7:0] OFS_FREQ = 8'h1c;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SONLY_BIT = 1;
	localparam int STS_START_BIT = 0;
	localparam int STS_TRIP_BIT = 1;
	localparam int STS_FOK_BIT = 2;
	localparam int EV_START_ON = 0;
	localparam int EV_START_OFF = 1;
	localparam int EV_TRIP_ON = 2;
	localparam int EV_TRIP_OFF = 3;
endpackage

// ==== freq_qualify.sv ====
/*
 Frequency acceptance filter: a value is taken after four valid
 measurements in a row and dropped to zero after four invalid ones.
 Assumes one measurement strobe per period from the zero-crossing logic.
*/
`timescale 1ns/1ns
module freq_qualify import rocof_pkg::*; #(
	parameter int FREQ_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic meas_strobe,
	input wire logic meas_valid,
	input wire logic [FREQ_W-1:0] meas_freq,
	output logic [FREQ_W-1:0] freq_q,
	output logic freq_ok,
	output logic freq_upd
);
	if (FREQ_W < 8 || FREQ_W > 24) begin : g_bad_w
		$error("freq_qualify: FREQ_W out of range");
	end

	typedef struct packed {
		logic [2:0] vcnt;
		logic [2:0] icnt;
		logic [FREQ_W-1:0] freq;
		logic ok;
		logic upd;
	} qual_s;

	qual_s s_q;
	qual_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.upd = 1'b0;
		if (meas_strobe) begin
			if (meas_valid) begin
				s_d.icnt = 3'h0;
				if (s_q.vcnt < QUAL_CNT - 3'h1) begin
					s_d.vcnt = s_q.vcnt + 3'h1;
				end else begin
					s_d.vcnt = QUAL_CNT;
					s_d.freq = meas_freq;
					s_d.ok = 1'b1;
					s_d.upd = 1'b1;
				end
			end else begin
				s_d.vcnt = 3'h0;
				if (s_q.icnt < QUAL_CNT - 3'h1) begin
					// Last good value held meanwhile
					s_d.icnt = s_q.icnt + 3'h1;
				end else begin
					s_d.icnt = QUAL_CNT;
					s_d.freq = '0;
					s_d.ok = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign freq_q = s_q.freq;
	assign freq_ok = s_q.ok;
	assign freq_upd = s_q.upd;

	property p_zero_after_invalid;
		@(posedge clock) disable iff (rst)
		(s_q.icnt == QUAL_CNT) |-> (s_q.freq == '0 && !s_q.ok);
	endproperty
	a_zero_after_invalid: assert property (p_zero_after_invalid)
		else $error("frequency not cleared after invalid run");
endmodule

// ==== slope_calc.sv ====
/*
 Slope of frequency: difference to the value five accepted periods back,
 multiplied by the present frequency so no divider is needed.
 Assumes freq_upd pulses once per accepted period.
*/
`timescale 1ns/1ns
module slope_calc import rocof_pkg::*; #(
	parameter int FREQ_W = 16,
	parameter int DEPTH = HIST_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clear,
	input wire logic freq_upd,
	input wire logic [FREQ_W-1:0] freq,
	output logic signed [2*FREQ_W+1:0] prod_q,
	output logic prod_valid
);
	localparam int PW = 2 * FREQ_W + 2;
	localparam logic [2:0] DEPTH_C = 3'(DEPTH);

	if (DEPTH < 1 || DEPTH > 7) begin : g_bad_depth
		$error("slope_calc: DEPTH out of range");
	end

	typedef struct packed {
		logic [DEPTH-1:0][FREQ_W-1:0] hist;
		logic [2:0] fill;
		logic signed [PW-1:0] prod;
		logic pvalid;
	} slope_s;

	slope_s s_q;
	slope_s s_d;

	always_comb begin
		logic signed [FREQ_W:0] diff;
		logic signed [FREQ_W:0] f_s;
		diff = '0;
		f_s = $signed({1'b0, freq});
		s_d = s_q;
		if (clear) begin
			s_d.fill = 3'h0;
			s_d.pvalid = 1'b0;
		end else if (freq_upd) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				s_d.hist[i] = s_q.hist[i-1];
			end
			s_d.hist[0] = freq;
			if (s_q.fill == DEPTH_C) begin
				// Present sample against five periods earlier
				diff = f_s - $signed({1'b0, s_q.hist[DEPTH-1]});
				// Widen before the multiply so the full product survives
				s_d.prod = PW'(diff) * PW'(f_s);
				s_d.pvalid = 1'b1;
			end else begin
				s_d.fill = s_q.fill + 3'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prod_q = s_q.prod;
	assign prod_valid = s_q.pvalid;
endmodule

// ==== freq_source.sv ====
/*
 Far-side frequency source: one measurement strobe every PERIOD clocks,
 the frequency moving by slope mHz at each strobe.
 Assumes the bench changes slope and valid only after a clock edge.
*/
`timescale 1ns/1ns
module freq_source #(
	parameter int PERIOD = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic signed [15:0] slope,
	input wire logic valid,
	output logic meas_strobe,
	output logic meas_valid,
	output logic [15:0] meas_freq
);
	logic [15:0] freq_q;
	int cnt_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= 0;
			freq_q <= 16'hc350;
			meas_strobe <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			meas_strobe <= (cnt_q == 0);
			if (cnt_q == 0) freq_q <= freq_q + slope;
		end
	end
	// Junk outside the strobe so stale values are never trusted
	assign meas_valid = meas_strobe ? valid : ~valid;
	assign meas_freq = meas_strobe ? freq_q : ~freq_q;
endmodule

// ==== rocof_prot_tb_top.sv ====
/*
 Self-checking bench of the slope protection element: register tasks,
 a frequency source and queue-based checks of reads and events.
 Assumes a 1 ms tick of TICK clocks and the package register map.
*/
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
	num_errors++; $display("BAD %0t %s", $time, m); end end
module rocof_prot_tb_top import rocof_pkg::*;;
	localparam int TICK = 4;
	localparam int GAP = (200 - 100) * TICK;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic signed [15:0] slope = 16'h0000;
	logic valid = 1'b1;
	logic [15:0] volt_mag = 16'h03e8;
	logic blk = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_pend = 1'b0;
	logic [31:0] reg_rdata;
	logic irq, start_out, trip_out, start_event, trip_event;
	logic strobe, mvalid;
	logic [15:0] mfreq;
	logic [31:0] rq[$];
	logic sq[$];
	logic tq[$];
	int num_errors = 0;
	int check_count = 0;
	int n, step, rated_v;

	freq_source src (.clock(clock), .rst(rst), .slope(slope),
		.valid(valid), .meas_strobe(strobe), .meas_valid(mvalid),
		.meas_freq(mfreq));
	rocof_prot #(.TICK_CYCLES(TICK)) uut (.clock(clock), .rst(rst),
		.meas_strobe(strobe), .meas_valid(mvalid), .meas_freq(mfreq),
		.volt_mag(volt_mag), .rocof_block_in(blk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq),
		.rocof_general_start_out(start_out),
		.rocof_general_trip_out(trip_out), .start_event(start_event),
		.trip_event(trip_event));

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask

	task automatic run(input int c);
		repeat (c) @(posedge clock);
	endtask

	// Bounded wait for an output level, n counts the edges spent
	task automatic wait_for(input bit t, input logic lvl, output int c);
		c = 0;
		while ((t ? trip_out : start_out) !== lvl) begin
			@(posedge clock);
			c++;
			if (c > 3000) begin
				num_errors++;
				$display("BAD %0t output wait ran out", $time);
				finish_test();
			end
		end
	endtask

	task automatic ev(input logic lvl, ref logic q[$], input string m);
		if (q.size() == 0) `CHK(1'b0, 1'b1, m)
		else `CHK(lvl, q.pop_front(), m)
	endtask

	always @(posedge clock) begin
		rd_pend <= reg_rd;
		if (rd_pend) begin
			if (rq.size() == 0) `CHK(1'b0, 1'b1, "extra read")
			else `CHK(reg_rdata, rq.pop_front(), "read data")
		end
		if (start_event === 1'b1) ev(start_out, sq, "start event");
		if (trip_event === 1'b1) ev(trip_out, tq, "trip event");
	end

	initial begin
		void'($urandom(90));
		step = 20 + $urandom % 16;
		rated_v = 500 + $urandom % 1000;
		run(16);
		rst <= 1'b0;
		volt_mag <= 16'(1000 + $urandom % 1000);
		@(posedge clock);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_THR, {22'h0, THR_RST});
		rd(OFS_DLY, {18'h0, DLY_RST});
		rd(OFS_RATED, {16'h0, RATED_RST});
		wr(OFS_RATED, 32'(rated_v));
		rd(OFS_RATED, 32'(rated_v));
		rd(8'h20, 32'h0);
		// Out-of-range settings leave the old value
		wr(OFS_THR, 32'(501 + $urandom % 11));
		wr(OFS_THR, 32'hfffffe0b);
		wr(OFS_DLY, 32'($urandom % 200));
		wr(OFS_DLY, 32'h2711);
		rd(OFS_THR, 32'h32);
		rd(OFS_DLY, 32'hc8);
		wr(OFS_DLY, 32'h2710);
		rd(OFS_DLY, 32'h2710);
		wr(OFS_DLY, 32'hc8);
		slope <= 16'(step);
		run(1200);
		`CHK({start_out, trip_out}, 2'b00, "disabled out")
		slope <= 16'h0;
		run(200);
		wr(OFS_IMASK, 32'h5);
		rd(OFS_IMASK, 32'h5);
		wr(OFS_CTRL, 32'h1);
		sq.push_back(1'b1);
		tq.push_back(1'b1);
		slope <= 16'(step);
		wait_for(0, 1'b1, n);
		wait_for(1, 1'b1, n);
		`CHK(n >= GAP - TICK && n <= GAP + TICK, 1'b1, "trip gap")
		`CHK(irq, 1'b1, "irq on")
		rd(OFS_STATUS, 32'h7);
		sq.push_back(1'b0);
		tq.push_back(1'b0);
		slope <= 16'h0;
		wait_for(0, 1'b0, n);
		wait_for(1, 1'b0, n);
		wr(OFS_ISTAT, 32'h5);
		`CHK(irq, 1'b0, "irq masked")
		rd(OFS_ISTAT, 32'ha);
		wr(OFS_ISTAT, 32'ha);
		rd(OFS_ISTAT, 32'h0);
		blk <= 1'b1;
		slope <= 16'(step);
		run(1500);
		`CHK({start_out, trip_out}, 2'b00, "blocked out")
		sq.push_back(1'b1);
		tq.push_back(1'b1);
		blk <= 1'b0;
		wait_for(1, 1'b1, n);
		`CHK(n <= 4, 1'b1, "unblock timer kept")
		sq.push_back(1'b0);
		tq.push_back(1'b0);
		blk <= 1'b1;
		wait_for(1, 1'b0, n);
		slope <= 16'h0;
		run(200);
		blk <= 1'b0;
		wr(OFS_CTRL, 32'h3);
		sq.push_back(1'b1);
		slope <= 16'(step);
		wait_for(0, 1'b1, n);
		run(1200);
		`CHK(trip_out, 1'b0, "start only")
		sq.push_back(1'b0);
		slope <= 16'h0;
		wait_for(0, 1'b0, n);
		// Old fault lasted past the delay, so a kept timer trips at once
		wr(OFS_CTRL, 32'h1);
		sq.push_back(1'b1);
		tq.push_back(1'b1);
		slope <= 16'(step);
		wait_for(0, 1'b1, n);
		wait_for(1, 1'b1, n);
		`CHK(n >= GAP - TICK && n <= GAP + TICK, 1'b1, "restart")
		sq.push_back(1'b0);
		tq.push_back(1'b0);
		slope <= 16'h0;
		wait_for(1, 1'b0, n);
		run(200);
		// Exactly a tenth of rated must not count as enough voltage
		volt_mag <= 16'(rated_v / 10);
		slope <= 16'(step);
		run(1200);
		`CHK(start_out, 1'b0, "low voltage")
		slope <= 16'h0;
		run(200);
		volt_mag <= 16'(rated_v / 10 + 1 + $urandom % 50);
		wr(OFS_THR, 32'hffffffce);
		sq.push_back(1'b1);
		slope <= 16'(-step);
		wait_for(0, 1'b1, n);
		`CHK({start_out, trip_out}, 2'b10, "negative threshold")
		sq.push_back(1'b0);
		slope <= 16'h0;
		wait_for(0, 1'b0, n);
		valid <= 1'b0;
		run(16 * 6);
		rd(OFS_FREQ, 32'h0);
		rd(OFS_STATUS, 32'h0);
		run(4);
		`CHK(rq.size() + sq.size() + tq.size(), 0, "pending notes")
		finish_test();
	end
endmodule
